// file: pfcm_pkg.sv
// pfcm_pkg: command codes, reset values, fault masks and carrier types
// assumes fault comparators, straps and bus pins arrive from outside the clock domain
// How it works
// - latching faults hold until bias recycle or enable toggle
// - early overvoltage latch clears only on bias recycle
// - severe faults drive severe output and host alert
// - input voltage faults counted only while enabled, alert-only
// - sense pin shorts latch off, alert, no severe
// - bus address from one strap, sixteen choices
// - unlisted command codes never change configuration
// - strap config loads first; host writes after power-up
// - on/off control byte 01h, margin select, default 00h
// - turn-on source byte 02h, default 17h
// - clear-faults 03h clears status, releases alert
// - write lock byte 10h blocks other writes
// - 11h stores settings to NVM, 12h restores
// - feature report 19h reads fixed B0h
// - voltage format 20h reads fixed 21h
// - voltage target 21h word, starts at boot value
// - margin high/low words 25h/26h, default zero
// - current reading trim word 39h, default zero
// - fixed response bytes 41h=80h, 45h=BAh
// - trip level 46h, 125% imax, alert-only fault
// - 47h reads FAh; 4Ah warning defaults imax
// - severe output driven low on severe faults
// - large strap resistance selects NVM config source
package pfcm_pkg;
    localparam logic [7:0] CMD_OP = 8'h01;
    localparam logic [7:0] CMD_CFG = 8'h02;
    localparam logic [7:0] CMD_CLR = 8'h03;
    localparam logic [7:0] CMD_LOCK = 8'h10;
    localparam logic [7:0] CMD_STORE = 8'h11;
    localparam logic [7:0] CMD_RESTORE = 8'h12;
    localparam logic [7:0] CMD_FEAT = 8'h19;
    localparam logic [7:0] CMD_VFMT = 8'h20;
    localparam logic [7:0] CMD_VTGT = 8'h21;
    localparam logic [7:0] CMD_VMAX = 8'h24;
    localparam logic [7:0] CMD_VMH = 8'h25;
    localparam logic [7:0] CMD_VML = 8'h26;
    localparam logic [7:0] CMD_TRIM = 8'h39;
    localparam logic [7:0] CMD_OVACT = 8'h41;
    localparam logic [7:0] CMD_UVACT = 8'h45;
    localparam logic [7:0] CMD_OCTRIP = 8'h46;
    localparam logic [7:0] CMD_OCACT = 8'h47;
    localparam logic [7:0] CMD_OCWARN = 8'h4a;
    localparam logic [7:0] CMD_OTTRIP = 8'h4f;
    localparam logic [7:0] CMD_STATUS = 8'h79;
    localparam logic [7:0] RST_OP = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h17;
    localparam logic [7:0] RST_LOCK = 8'h00;
    localparam logic [7:0] VAL_FEAT = 8'hb0;
    localparam logic [7:0] VAL_VFMT = 8'h21;
    localparam logic [7:0] VAL_OVACT = 8'h80;
    localparam logic [7:0] VAL_UVACT = 8'hba;
    localparam logic [7:0] VAL_OCACT = 8'hfa;
    localparam logic [15:0] RST_VMAX = 16'h00ff;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RST_OTTRIP = 16'h007d;
    localparam logic [7:0] LOCK_ALL = 8'h80;
    localparam logic [7:0] LOCK_OP = 8'h40;
    localparam logic [7:0] LOCK_VOUT = 8'h20;
    // fault bit order follows pfcm_fault_t, msb first
    localparam logic [14:0] SEVERE_SET = 15'h60a1;
    localparam logic [14:0] LATCH_SET = 15'h2087;
    localparam logic [14:0] ALERT_SET = 15'h7ff7;
    localparam logic [14:0] GATED_SET = 15'h0c00;
    localparam int EARLY_BIT = 14;
    localparam int IN_OV_BIT = 11;
    localparam int SHORT_REF_BIT = 2;
    typedef struct packed {
        logic early_overvoltage_fault;
        logic output_overvoltage_fault;
        logic output_undervoltage_fault;
        logic input_overvoltage_fault;
        logic input_undervoltage_fault;
        logic load_overcurrent_fault;
        logic load_overcurrent_warning;
        logic supply_overcurrent_fault;
        logic supply_overcurrent_warning;
        logic overheat_fault;
        logic overheat_warning;
        logic max_temp_flag;
        logic sense_short_to_reference;
        logic sense_short_to_ground;
        logic power_stage_fault;
    } pfcm_fault_t;
    typedef struct packed {
        logic scl;
        logic sda;
        logic enable;
        logic bias_ok;
        pfcm_fault_t faults;
        logic [7:0] boot;
        logic [7:0] imax;
        logic [3:0] addr;
        logic config_source_strap;
    } pfcm_pins_t;
    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_ADDR = 5'b00010,
        PH_CMD = 5'b00100,
        PH_WR = 5'b01000,
        PH_RD = 5'b10000
    } pfcm_phase_t;
endpackage

// file: pfcm_core.sv
// pfcm_core: fault classification, bus command map and serial slave
// assumes scl/sda, enable, bias and fault levels are asynchronous; nvm values are local
`timescale 1ns/1ns
`default_nettype none
module pfcm_core
    import pfcm_pkg::*;
#(
    parameter int POWERUP_CYC = 1000,
    parameter logic [6:0] ADDR_BASE = 7'h50 // arbitrary base
)
(
    input wire logic i_ref_clk, // 50 MHz clock
    input wire logic i_reset, // async reset, high
    input wire logic i_scl, // bus clock pin
    input wire logic i_sda, // bus data pin level
    input wire logic i_enable_pin, // enable control pin
    input wire logic i_bias_ok, // main_bias_supply present
    input wire pfcm_fault_t i_faults, // comparator levels
    input wire logic [7:0] i_boot_strap, // boot code from straps
    input wire logic [7:0] i_imax_strap, // imax from straps
    input wire logic [3:0] i_address_strap_pin, // decoded address strap
    input wire logic i_config_source_strap, // high: large resistance
    input wire logic [7:0] i_nvm_boot, // boot code held in nvm
    input wire logic [7:0] i_nvm_imax, // imax held in nvm
    output logic o_sda_out, // data pin drive value
    output logic o_sda_oe, // data pin pull-low enable
    output logic o_severe_fault_out_n, // severe_fault_out, low active
    output logic o_host_alert_out_n, // host_alert_out, low active
    output logic o_hot_indicator_out_n, // hot_indicator_out, low active
    output logic o_output_on, // power stage enabled
    output logic o_latched_off, // latched shutdown
    output logic [15:0] o_vout_code, // clamped voltage target
    output logic [15:0] o_meas_trim, // current reading trim
    output logic o_nvm_store, // store pulse
    output logic o_nvm_restore // restore pulse
);
    if (POWERUP_CYC < 1 || POWERUP_CYC > 65535)
    begin : g_chk
        $error("POWERUP_CYC out of range");
    end
    localparam logic [15:0] PU_LAST = 16'(POWERUP_CYC - 1);

    // ==========================================================
    // input synchroniser
    pfcm_pins_t raw, pin_m_r, pin_r;
    logic scl_d_r, sda_d_r;
    assign raw = {i_scl, i_sda, i_enable_pin, i_bias_ok, i_faults, i_boot_strap,
                  i_imax_strap, i_address_strap_pin, i_config_source_strap};
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pin_m_r <= '{scl: 1'b1, sda: 1'b1, default: '0}; // idle bus levels: no false edge after reset
            pin_r <= '{scl: 1'b1, sda: 1'b1, default: '0};
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            pin_m_r <= raw;
            pin_r <= pin_m_r;
            scl_d_r <= pin_r.scl;
            sda_d_r <= pin_r.sda;
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = pin_r.scl & ~scl_d_r;
    assign scl_fall = ~pin_r.scl & scl_d_r;
    assign start_c = pin_r.scl & scl_d_r & sda_d_r & ~pin_r.sda;
    assign stop_c = pin_r.scl & scl_d_r & ~sda_d_r & pin_r.sda;

    // ==========================================================
    // power-up sequence and strap capture
    logic [15:0] pu_cnt_r;
    logic pu_done_r, pu_end;
    logic [6:0] addr_r;
    assign pu_end = ~pu_done_r & (pu_cnt_r == PU_LAST);
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pu_cnt_r <= '0;
            pu_done_r <= 1'b0;
            addr_r <= ADDR_BASE;
        end
        else if (~pu_done_r)
        begin
            pu_cnt_r <= pu_cnt_r + 16'd1;
            if (pu_end)
            begin
                pu_done_r <= 1'b1;
                addr_r <= ADDR_BASE | {3'b000, pin_r.addr};
            end
        end
    end

    // ==========================================================
    // serial slave
    pfcm_phase_t phase_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, tx_r, cmd_r, d0_r, d1_r, tx_byte;
    logic [1:0] nb_r;
    logic mack_r, rbi_r, wr_go_r;
    logic [15:0] rd_word;
    assign tx_byte = rbi_r ? rd_word[15:8] : rd_word[7:0];
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            phase_r <= PH_IDLE;
            cnt_r <= '0;
            sh_r <= '0;
            tx_r <= '0;
            cmd_r <= '0;
            d0_r <= '0;
            d1_r <= '0;
            nb_r <= '0;
            mack_r <= 1'b0;
            rbi_r <= 1'b0;
            wr_go_r <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else
        begin
            wr_go_r <= 1'b0;
            if (start_c)
            begin
                phase_r <= PH_ADDR;
                cnt_r <= 4'hf; // the clock fall closing a start is no bit; it wraps to zero
                o_sda_oe <= 1'b0;
            end
            else if (stop_c)
            begin
                wr_go_r <= (phase_r == PH_WR);
                phase_r <= PH_IDLE;
                o_sda_oe <= 1'b0;
            end
            else if (phase_r != PH_IDLE)
            begin
                if (scl_rise)
                begin
                    if (cnt_r != 4'd8)
                        sh_r <= {sh_r[6:0], pin_r.sda};
                    else
                        mack_r <= ~pin_r.sda;
                end
                else if (scl_fall)
                begin
                    if (cnt_r == 4'd7)
                    begin
                        cnt_r <= 4'd8;
                        o_sda_oe <= 1'b1;
                        case (phase_r)
                            PH_ADDR:
                            begin
                                if (sh_r[7:1] == addr_r)
                                begin
                                    phase_r <= sh_r[0] ? PH_RD : PH_CMD;
                                    mack_r <= 1'b1;
                                    rbi_r <= 1'b0;
                                end
                                else
                                begin
                                    phase_r <= PH_IDLE;
                                    o_sda_oe <= 1'b0;
                                end
                            end
                            PH_CMD:
                            begin
                                cmd_r <= sh_r;
                                nb_r <= '0;
                                phase_r <= PH_WR;
                            end
                            PH_WR:
                            begin
                                if (nb_r == 2'd0)
                                    d0_r <= sh_r;
                                if (nb_r == 2'd1)
                                    d1_r <= sh_r;
                                if (nb_r != 2'd3)
                                    nb_r <= nb_r + 2'd1;
                            end
                            default: o_sda_oe <= 1'b0;
                        endcase
                    end
                    else if (cnt_r == 4'd8)
                    begin
                        cnt_r <= '0;
                        if (phase_r == PH_RD && mack_r)
                        begin
                            tx_r <= tx_byte;
                            o_sda_oe <= ~tx_byte[7];
                            rbi_r <= ~rbi_r;
                        end
                        else
                        begin
                            o_sda_oe <= 1'b0;
                            if (phase_r == PH_RD)
                                phase_r <= PH_IDLE;
                        end
                    end
                    else
                    begin
                        cnt_r <= cnt_r + 4'd1;
                        if (phase_r == PH_RD)
                        begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            o_sda_oe <= ~tx_r[6];
                        end
                    end
                end
            end
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
            o_sda_out <= 1'b0;
        else
            o_sda_out <= 1'b0;
    end

    // ==========================================================
    // command map
    logic [7:0] op_r, cfg_r, lock_r;
    logic [15:0] vtgt_r, vmax_r, vmh_r, vml_r, octrip_r, ocwarn_r, ottrip_r;
    pfcm_fault_t status_r;
    logic lock_ok, wr_ok, byte_wr, word_wr, send_wr, clr_go, restore_go, load_go;
    logic [7:0] ld_boot, ld_imax;
    logic [15:0] wdata;
    always_comb
    begin
        case (lock_r)
            LOCK_ALL: lock_ok = (cmd_r == CMD_LOCK);
            LOCK_OP: lock_ok = (cmd_r == CMD_LOCK) || (cmd_r == CMD_OP);
            LOCK_VOUT: lock_ok = (cmd_r == CMD_LOCK) || (cmd_r == CMD_OP) ||
                                 (cmd_r == CMD_CFG) || (cmd_r == CMD_VTGT);
            default: lock_ok = 1'b1;
        endcase
    end
    assign wr_ok = wr_go_r & pu_done_r & lock_ok;
    assign byte_wr = wr_ok & (nb_r == 2'd1);
    assign word_wr = wr_ok & (nb_r == 2'd2);
    assign send_wr = wr_ok & (nb_r == 2'd0);
    assign clr_go = send_wr & (cmd_r == CMD_CLR);
    assign restore_go = send_wr & (cmd_r == CMD_RESTORE);
    assign load_go = pu_end | restore_go;
    assign wdata = {d1_r, d0_r};
    assign ld_boot = (restore_go | pin_r.config_source_strap) ? i_nvm_boot : pin_r.boot;
    assign ld_imax = (restore_go | pin_r.config_source_strap) ? i_nvm_imax : pin_r.imax;
    always_comb
    begin
        case (cmd_r)
            CMD_OP: rd_word = {8'h00, op_r};
            CMD_CFG: rd_word = {8'h00, cfg_r};
            CMD_LOCK: rd_word = {8'h00, lock_r};
            CMD_FEAT: rd_word = {8'h00, VAL_FEAT};
            CMD_VFMT: rd_word = {8'h00, VAL_VFMT};
            CMD_VTGT: rd_word = vtgt_r;
            CMD_VMAX: rd_word = vmax_r;
            CMD_VMH: rd_word = vmh_r;
            CMD_VML: rd_word = vml_r;
            CMD_TRIM: rd_word = o_meas_trim;
            CMD_OVACT: rd_word = {8'h00, VAL_OVACT};
            CMD_UVACT: rd_word = {8'h00, VAL_UVACT};
            CMD_OCTRIP: rd_word = octrip_r;
            CMD_OCACT: rd_word = {8'h00, VAL_OCACT};
            CMD_OCWARN: rd_word = ocwarn_r;
            CMD_OTTRIP: rd_word = ottrip_r;
            CMD_STATUS: rd_word = {1'b0, status_r};
            default: rd_word = 16'hffff;
        endcase
    end
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            op_r <= RST_OP;
            cfg_r <= RST_CFG;
            lock_r <= RST_LOCK;
            vtgt_r <= RST_WORD;
            vmax_r <= RST_VMAX;
            vmh_r <= RST_WORD;
            vml_r <= RST_WORD;
            o_meas_trim <= RST_WORD;
            octrip_r <= RST_WORD;
            ocwarn_r <= RST_WORD;
            ottrip_r <= RST_OTTRIP;
        end
        else if (load_go)
        begin
            vtgt_r <= {8'h00, ld_boot};
            octrip_r <= 16'(ld_imax) + 16'(ld_imax[7:2]);
            ocwarn_r <= {8'h00, ld_imax};
        end
        else if (byte_wr)
        begin
            case (cmd_r)
                CMD_OP: op_r <= d0_r;
                CMD_CFG: cfg_r <= d0_r;
                CMD_LOCK: lock_r <= d0_r;
                default: ;
            endcase
        end
        else if (word_wr)
        begin
            case (cmd_r)
                CMD_VTGT: vtgt_r <= wdata;
                CMD_VMAX: vmax_r <= wdata;
                CMD_VMH: vmh_r <= wdata;
                CMD_VML: vml_r <= wdata;
                CMD_TRIM: o_meas_trim <= wdata;
                CMD_OCTRIP: octrip_r <= wdata;
                CMD_OCWARN: ocwarn_r <= wdata;
                CMD_OTTRIP: ottrip_r <= wdata;
                default: ;
            endcase
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_nvm_store <= 1'b0;
            o_nvm_restore <= 1'b0;
        end
        else
        begin
            o_nvm_store <= send_wr & (cmd_r == CMD_STORE);
            o_nvm_restore <= restore_go;
        end
    end

    // ==========================================================
    // fault handling and output control
    logic [14:0] live, status_nxt;
    logic lat_early_r, lat_other_r, en_act, on_req;
    logic [15:0] vsel;
    assign en_act = ~(pin_r.enable ^ cfg_r[1]) ? 1'b1 : 1'b0;
    assign live = pin_r.faults & ~(o_output_on ? 15'h0000 : GATED_SET);
    assign status_nxt = live | (clr_go ? 15'h0000 : status_r);
    assign on_req = ~cfg_r[4] | ((~cfg_r[3] | op_r[7]) & (~cfg_r[2] | en_act));
    assign vsel = (op_r[5:4] == 2'b10) ? vmh_r : (op_r[5:4] == 2'b01) ? vml_r : vtgt_r;
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            lat_early_r <= 1'b0;
            lat_other_r <= 1'b0;
        end
        else
        begin
            lat_early_r <= live[EARLY_BIT] | (lat_early_r & pin_r.bias_ok);
            lat_other_r <= (|(live & LATCH_SET)) | (lat_other_r & pin_r.bias_ok & en_act);
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            status_r <= '0;
            o_host_alert_out_n <= 1'b1;
            o_severe_fault_out_n <= 1'b1;
            o_hot_indicator_out_n <= 1'b1;
        end
        else
        begin
            status_r <= status_nxt;
            o_host_alert_out_n <= ~(|(status_nxt & ALERT_SET));
            o_severe_fault_out_n <= ~((|(live & SEVERE_SET)) | lat_early_r);
            o_hot_indicator_out_n <= ~live[3];
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_output_on <= 1'b0;
            o_latched_off <= 1'b0;
            o_vout_code <= RST_WORD;
        end
        else
        begin
            o_output_on <= on_req & pu_done_r & ~(lat_early_r | lat_other_r);
            o_latched_off <= lat_early_r | lat_other_r;
            o_vout_code <= (vsel > vmax_r) ? vmax_r : vsel;
        end
    end

    // ==========================================================
    // assertions
    early_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        lat_early_r && pin_r.bias_ok |=> lat_early_r) else $error("early latch lost");
    other_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $fell(lat_other_r) |-> !$past(pin_r.bias_ok) || !$past(en_act)) else $error("latch cleared early");
    severe_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        |(live & SEVERE_SET) |=> !o_severe_fault_out_n) else $error("severe not driven");
    gated_input_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(status_r[IN_OV_BIT]) |-> $past(o_output_on)) else $error("input fault while off");
    short_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        live[SHORT_REF_BIT] && !(|(live & SEVERE_SET)) && !lat_early_r
        |=> o_severe_fault_out_n && lat_other_r ##1 !o_host_alert_out_n) else $error("short response");
    alert_sticky_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !o_host_alert_out_n && !clr_go |=> !o_host_alert_out_n) else $error("alert dropped");
    clear_release_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        clr_go && !(|(live & ALERT_SET)) |=> o_host_alert_out_n && status_r == '0) else $error("clear");
    lock_block_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        wr_go_r && lock_r == LOCK_ALL && cmd_r != CMD_LOCK |=> $stable(op_r) && $stable(vtgt_r))
        else $error("locked write taken");
    vout_clamp_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        ##1 o_vout_code <= $past(vmax_r)) else $error("ceiling exceeded");
    early_write_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        wr_go_r && !pu_done_r |=> $stable(op_r) && $stable(lock_r)) else $error("write before power-up");
    clear_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) clr_go);
    word_write_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) word_wr);
    early_latch_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) $rose(lat_early_r));
    read_phase_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) phase_r == PH_RD ##1 scl_fall);
endmodule
`default_nettype wire

// file: pfcm_host.sv
// pfcm_host: bus master model, driven clock, open-drain data
// assumes the bench resolves sda from every pull-low enable
`timescale 1ns/1ns
`default_nettype none
module pfcm_host
#(
    parameter logic [6:0] ADR = 7'h55
)
(
    input wire logic i_ref_clk, // bench clock
    input wire logic i_sda, // resolved data line
    output logic o_scl, // bus clock, idle high
    output logic o_sda_low // pull data low
);
    initial o_scl = 1'b1;
    initial o_sda_low = 1'b0;
    // quarter bit: two clocks, so one bit is 160 ns
    task automatic tq();
        repeat (2) @(posedge i_ref_clk);
        #2;
    endtask
    task automatic bit_io(input logic b, output logic r);
        tq();
        o_sda_low = !b;
        tq();
        o_scl = 1'b1;
        tq();
        r = i_sda;
        tq();
        o_scl = 1'b0;
    endtask
    task automatic start();
        tq();
        o_sda_low = 1'b0;
        tq();
        o_scl = 1'b1;
        tq();
        o_sda_low = 1'b1;
        tq();
        o_scl = 1'b0;
    endtask
    task automatic stop();
        tq();
        o_sda_low = 1'b1;
        tq();
        o_scl = 1'b1;
        tq();
        o_sda_low = 1'b0;
        tq();
    endtask
    // eight bits msb first, then the acknowledge bit
    task automatic xb(input logic [7:0] d, input logic last, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(last, a);
    endtask
    // n data bytes, low byte first
    task automatic wr(input logic [6:0] ad, input logic [7:0] c, input logic [15:0] d, input int n,
        output logic ak);
        logic [7:0] r;
        logic a;
        start();
        xb({ad, 1'b0}, 1'b1, r, ak);
        xb(c, 1'b1, r, a);
        if (n > 0)
            xb(d[7:0], 1'b1, r, a);
        if (n > 1)
            xb(d[15:8], 1'b1, r, a);
        stop();
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        logic [7:0] r;
        logic a;
        start();
        xb({ADR, 1'b0}, 1'b1, r, a);
        xb(c, 1'b1, r, a);
        start();
        xb({ADR, 1'b1}, 1'b1, r, a);
        xb(8'hff, 1'b0, v[7:0], a);
        xb(8'hff, 1'b1, v[15:8], a);
        stop();
    endtask
endmodule
`default_nettype wire

// file: tb_pmbus_fault_command_map.sv
// tb_pmbus_fault_command_map: register map and fault response checks
// assumes pfcm_host as bus master and a pull-up on sda
`timescale 1ns/1ns
`default_nettype none
module tb_pmbus_fault_command_map;
    import pfcm_pkg::*;
    logic clk = 0, rst = 1, en = 1, bias = 1, scl, hl, oe, sev_n, al_n, hot_n, on, lat, st, rs, ak, cs = 0;
    logic [7:0] nb = 8'h33, ni = 8'h20;
    logic [15:0] vc, trim, v;
    pfcm_fault_t flt = '0;
    wire logic sda = !(hl | oe);
    int errors = 0, checks = 0, pulses = 0;
    localparam logic [7:0] RC [15] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h39,
        8'h41, 8'h45, 8'h46, 8'h47, 8'h4a};
    localparam logic [15:0] RV [15] = '{16'h0, 16'h17, 16'h0, 16'hb0, 16'h21, 16'h9a, 16'hff, 16'h0, 16'h0,
        16'h0, 16'h80, 16'hba, 16'h50, 16'hfa, 16'h40};
    always #10 clk = !clk;
    // store pulses count 1, restore pulses count 16
    always @(posedge clk) pulses <= pulses + int'(st === 1'b1) + 16 * int'(rs === 1'b1);
    pfcm_host #(.ADR(7'h55)) host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(hl));
    pfcm_core #(.POWERUP_CYC(300)) dut (.i_ref_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda),
        .i_enable_pin(en), .i_bias_ok(bias), .i_faults(flt), .i_boot_strap(8'h9a), .i_imax_strap(8'h40),
        .i_address_strap_pin(4'h5), .i_config_source_strap(cs), .i_nvm_boot(nb), .i_nvm_imax(ni),
        .o_sda_out(), .o_sda_oe(oe), .o_severe_fault_out_n(sev_n), .o_host_alert_out_n(al_n),
        .o_hot_indicator_out_n(hot_n), .o_output_on(on), .o_latched_off(lat), .o_vout_code(vc),
        .o_meas_trim(trim), .o_nvm_store(st), .o_nvm_restore(rs));
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    // flags in order severe_n, alert_n, latched, on
    task automatic chkf(input logic [3:0] e);
        tk(8);
        chk({12'h0, sev_n, al_n, lat, on}, {12'h0, e});
    endtask
    task automatic w(input logic [7:0] c, input logic [15:0] d, input int n);
        host.wr(7'h55, c, d, n, ak);
        tk(4);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 15; i++)
        begin
            host.rd(RC[i], v);
            chk(v, RV[i]);
        end
        chk(vc, 16'h009a);
        chkf(4'b1101);
        $display("regs done");
    endtask
    task automatic t_write();
        w(8'h19, 16'h55, 1);
        host.rd(8'h19, v);
        chk(v, 16'h00b0);
        w(8'h30, 16'h77, 1);
        host.rd(8'h30, v);
        chk(v, 16'hffff);
        w(8'h21, 16'h0123, 2);
        chk(vc, 16'h00ff);
        w(8'h25, 16'h0040, 2);
        w(8'h01, 16'ha0, 1);
        chk(vc, 16'h0040);
        w(8'h39, 16'h1234, 2);
        chk(trim, 16'h1234);
        host.wr(7'h54, 8'h39, 16'h0, 2, ak);
        chk({15'h0, ak}, 16'h1);
        w(8'h10, 16'h80, 1);
        w(8'h01, 16'h00, 1);
        chk(vc, 16'h0040);
        w(8'h10, 16'h00, 1);
        w(8'h01, 16'h00, 1);
        chk(vc, 16'h00ff);
        w(8'h11, 16'h0, 0);
        w(8'h12, 16'h0, 0);
        chk(vc, 16'h0033);
        chk(16'(pulses), 16'h0011);
        $display("write done");
    endtask
    task automatic t_fault();
        flt.max_temp_flag = 1'b1;
        chkf(4'b1101);
        chk({15'h0, hot_n}, 16'h0);
        flt.max_temp_flag = 1'b0;
        flt.input_overvoltage_fault = 1'b1;
        chkf(4'b1001);
        flt.supply_overcurrent_fault = 1'b1;
        chkf(4'b0010);
        flt = '0;
        chkf(4'b1010);
        w(8'h03, 16'h0, 0);
        chkf(4'b1110);
        flt.input_undervoltage_fault = 1'b1;
        chkf(4'b1110);
        flt = '0;
        en = 1'b0;
        tk(8);
        en = 1'b1;
        chkf(4'b1101);
        flt.sense_short_to_ground = 1'b1;
        flt.sense_short_to_reference = 1'b1;
        chkf(4'b1010);
        flt = '0;
        en = 1'b0;
        tk(8);
        en = 1'b1;
        w(8'h03, 16'h0, 0);
        flt.early_overvoltage_fault = 1'b1;
        tk(8);
        flt = '0;
        en = 1'b0;
        tk(8);
        en = 1'b1;
        chkf(4'b0010);
        bias = 1'b0;
        tk(8);
        bias = 1'b1;
        tk(8);
        chk({15'h0, lat}, 16'h0);
        $display("fault done");
    endtask
    // second reset: nvm source, write to the pre-capture address is dropped
    task automatic t_boot();
        cs = 1'b1;
        rst = 1'b1;
        tk(3);
        rst = 1'b0;
        host.wr(7'h50, 8'h01, 16'h0080, 1, ak);
        tk(100);
        host.rd(8'h01, v);
        chk(v, 16'h0000);
        chk(vc, 16'h0033);
        host.rd(8'h4a, v);
        chk(v, 16'h0020);
        $display("boot done");
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        tk(3);
        rst = 1'b0;
        tk(320);
        t_regs();
        t_write();
        t_fault();
        t_boot();
        finish_test();
    end
    initial
    begin
        #2000000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
